// ==== hw/rosel_pkg.sv ====
// constants for the remappable output select block
// Operation
// - each pin has writable 5-bit function code
// - bits 4-0 select even pin
// - bits 12-8 select odd pin
// - five registers cover pins zero to nine
// - unused bits read zero, ignore writes
package rosel_pkg;
    localparam int unsigned NUM_PINS = 10;
    localparam int unsigned NUM_REGS = 5;
    localparam int unsigned CODE_W = 5;
    localparam int unsigned EVEN_LSB = 0;
    localparam int unsigned ODD_LSB = 8;
    localparam int unsigned ADDR_W = 8;
    // byte offsets of output_select_pins_0_1 .. output_select_pins_8_9
    localparam logic [7:0] OFS_PINS_0_1 = 8'h00;
    localparam logic [7:0] OFS_PINS_2_3 = 8'h04;
    localparam logic [7:0] OFS_PINS_4_5 = 8'h08;
    localparam logic [7:0] OFS_PINS_6_7 = 8'h0C;
    localparam logic [7:0] OFS_PINS_8_9 = 8'h10;
    localparam logic [4:0] CODE_RESET = 5'h00;
    localparam logic [4:0] CODE_NONE = 5'h00;
    localparam logic [15:0] REG_MASK = 16'h1F1F;
endpackage

// ==== hw/rosel_top.sv ====
// remappable output select registers and per-pin function mux
`timescale 1ns/1ps
`default_nettype none
module rosel_top #(
    parameter int unsigned NUM_FUNCS = 32
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    input wire logic [NUM_FUNCS-1:0] func_out_i,
    input wire logic [NUM_FUNCS-1:0] func_oe_i,
    input wire logic [9:0] port_out_i,
    input wire logic [9:0] port_oe_i,
    output logic [9:0] remappable_pin_o,
    output logic [9:0] remappable_pin_oe_o,
    output logic [49:0] pin_function_codes_o
);
    // --------------------------------------------------------------
    // storage
    // --------------------------------------------------------------
    // one code per remappable pin, two pins share a register
    logic [rosel_pkg::CODE_W-1:0] code_ff [0:rosel_pkg::NUM_PINS-1];
    wire [rosel_pkg::CODE_W-1:0] nxt_code [0:rosel_pkg::NUM_PINS-1];
    // bus answer, registered one-cycle pulses
    logic ack_ff;
    wire nxt_ack;
    logic err_ff;
    wire nxt_err;
    logic [31:0] dat_ff;
    wire [31:0] nxt_dat;

    // --------------------------------------------------------------
    // helper functions
    // --------------------------------------------------------------
    // true for any of the five register offsets
    function automatic logic reg_hit(input logic [7:0] adr);
        logic found;
        found = 1'b0;
        if (adr == rosel_pkg::OFS_PINS_0_1) begin
            found = 1'b1;
        end else if (adr == rosel_pkg::OFS_PINS_2_3) begin
            found = 1'b1;
        end else if (adr == rosel_pkg::OFS_PINS_4_5) begin
            found = 1'b1;
        end else if (adr == rosel_pkg::OFS_PINS_6_7) begin
            found = 1'b1;
        end else if (adr == rosel_pkg::OFS_PINS_8_9) begin
            found = 1'b1;
        end
        return found;
    endfunction

    // register number of an offset; unmapped gives zero
    function automatic logic [2:0] reg_index(input logic [7:0] adr);
        logic [2:0] index;
        index = 3'h0;
        if (adr == rosel_pkg::OFS_PINS_2_3) begin
            index = 3'h1;
        end else if (adr == rosel_pkg::OFS_PINS_4_5) begin
            index = 3'h2;
        end else if (adr == rosel_pkg::OFS_PINS_6_7) begin
            index = 3'h3;
        end else if (adr == rosel_pkg::OFS_PINS_8_9) begin
            index = 3'h4;
        end
        return index;
    endfunction

    // even pin field of a bus word
    function automatic logic [rosel_pkg::CODE_W-1:0] even_field(input logic [31:0] word);
        return word[rosel_pkg::EVEN_LSB +: rosel_pkg::CODE_W];
    endfunction

    // odd pin field of a bus word
    function automatic logic [rosel_pkg::CODE_W-1:0] odd_field(input logic [31:0] word);
        return word[rosel_pkg::ODD_LSB +: rosel_pkg::CODE_W];
    endfunction

    // register image; unused bits stay zero
    function automatic logic [15:0] pack_word(input logic [rosel_pkg::CODE_W-1:0] even,
            input logic [rosel_pkg::CODE_W-1:0] odd);
        logic [15:0] word;
        word = 16'h0000;
        word[rosel_pkg::EVEN_LSB +: rosel_pkg::CODE_W] = even;
        word[rosel_pkg::ODD_LSB +: rosel_pkg::CODE_W] = odd;
        return word;
    endfunction

    // new code when its lane is written, else the old one
    function automatic logic [rosel_pkg::CODE_W-1:0] lane_update(
            input logic [rosel_pkg::CODE_W-1:0] old_code,
            input logic wr_en,
            input logic [rosel_pkg::CODE_W-1:0] new_code);
        logic [rosel_pkg::CODE_W-1:0] result;
        result = old_code;
        if (wr_en) begin
            result = new_code;
        end
        return result;
    endfunction

    // zero and codes past the function table leave the pin to its port
    function automatic logic code_live(input logic [rosel_pkg::CODE_W-1:0] code);
        return (code != rosel_pkg::CODE_NONE) && (32'(code) < NUM_FUNCS);
    endfunction

    // function bit for a live code, port bit otherwise
    function automatic logic pick(input logic live, input logic [NUM_FUNCS-1:0] funcs,
            input logic [rosel_pkg::CODE_W-1:0] code, input logic fallback);
        logic result;
        result = fallback;
        if (live) begin
            result = funcs[code];
        end
        return result;
    endfunction

    // --------------------------------------------------------------
    // bus decode
    // --------------------------------------------------------------
    wire req;
    wire hit;
    wire [2:0] idx;
    wire wr_even;
    wire wr_odd;
    wire rd_en;
    wire [rosel_pkg::CODE_W-1:0] even_code;
    wire [rosel_pkg::CODE_W-1:0] odd_code;
    wire [rosel_pkg::NUM_REGS-1:0] reg_sel;
    wire [15:0] reg_word [0:rosel_pkg::NUM_REGS-1];
    wire [15:0] rd_word;

    // a request is taken once; a pending ack or err blocks a repeat
    assign req = wb_cyc_i && wb_stb_i && !ack_ff && !err_ff;
    assign hit = reg_hit(wb_adr_i);
    assign idx = reg_index(wb_adr_i);
    // lane 0 carries the even code, lane 1 the odd code
    assign wr_even = req && hit && wb_we_i && wb_sel_i[0];
    assign wr_odd = req && hit && wb_we_i && wb_sel_i[1];
    assign rd_en = req && hit && !wb_we_i;
    assign even_code = even_field(wb_dat_i);
    assign odd_code = odd_field(wb_dat_i);
    assign rd_word = reg_word[idx];

    // --------------------------------------------------------------
    // per register select, next codes and read image
    // --------------------------------------------------------------
    // pins 0 and 1
    assign reg_sel[0] = hit && (idx == 3'h0);
    assign nxt_code[0] = lane_update(code_ff[0], wr_even && reg_sel[0], even_code);
    assign nxt_code[1] = lane_update(code_ff[1], wr_odd && reg_sel[0], odd_code);
    assign reg_word[0] = pack_word(code_ff[0], code_ff[1]);

    // pins 2 and 3
    assign reg_sel[1] = hit && (idx == 3'h1);
    assign nxt_code[2] = lane_update(code_ff[2], wr_even && reg_sel[1], even_code);
    assign nxt_code[3] = lane_update(code_ff[3], wr_odd && reg_sel[1], odd_code);
    assign reg_word[1] = pack_word(code_ff[2], code_ff[3]);

    // pins 4 and 5
    assign reg_sel[2] = hit && (idx == 3'h2);
    assign nxt_code[4] = lane_update(code_ff[4], wr_even && reg_sel[2], even_code);
    assign nxt_code[5] = lane_update(code_ff[5], wr_odd && reg_sel[2], odd_code);
    assign reg_word[2] = pack_word(code_ff[4], code_ff[5]);

    // pins 6 and 7
    assign reg_sel[3] = hit && (idx == 3'h3);
    assign nxt_code[6] = lane_update(code_ff[6], wr_even && reg_sel[3], even_code);
    assign nxt_code[7] = lane_update(code_ff[7], wr_odd && reg_sel[3], odd_code);
    assign reg_word[3] = pack_word(code_ff[6], code_ff[7]);

    // pins 8 and 9
    assign reg_sel[4] = hit && (idx == 3'h4);
    assign nxt_code[8] = lane_update(code_ff[8], wr_even && reg_sel[4], even_code);
    assign nxt_code[9] = lane_update(code_ff[9], wr_odd && reg_sel[4], odd_code);
    assign reg_word[4] = pack_word(code_ff[8], code_ff[9]);

    // --------------------------------------------------------------
    // bus response
    // --------------------------------------------------------------
    // ack for mapped offsets, err for anything else, one cycle each
    assign nxt_ack = req && hit;
    assign nxt_err = req && !hit;
    // read data stands only with its ack
    assign nxt_dat = rd_en ? {16'h0000, rd_word} : 32'h00000000;

    // --------------------------------------------------------------
    // registers
    // --------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < rosel_pkg::NUM_PINS; i++) begin
                code_ff[i] <= rosel_pkg::CODE_RESET;
            end
        end else begin
            for (int i = 0; i < rosel_pkg::NUM_PINS; i++) begin
                code_ff[i] <= nxt_code[i];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= nxt_ack;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            err_ff <= 1'b0;
        end else begin
            err_ff <= nxt_err;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_ff <= 32'h00000000;
        end else begin
            dat_ff <= nxt_dat;
        end
    end

    assign wb_ack_o = ack_ff;
    assign wb_err_o = err_ff;
    assign wb_dat_o = dat_ff;

    // --------------------------------------------------------------
    // pin mux
    // --------------------------------------------------------------
    wire [rosel_pkg::NUM_PINS-1:0] pin_live;

    // pin 0, even half of register 0
    assign pin_live[0] = code_live(code_ff[0]);
    assign remappable_pin_o[0] = pick(pin_live[0], func_out_i, code_ff[0], port_out_i[0]);
    assign remappable_pin_oe_o[0] = pick(pin_live[0], func_oe_i, code_ff[0], port_oe_i[0]);
    assign pin_function_codes_o[4:0] = code_ff[0];

    // pin 1, odd half of register 0
    assign pin_live[1] = code_live(code_ff[1]);
    assign remappable_pin_o[1] = pick(pin_live[1], func_out_i, code_ff[1], port_out_i[1]);
    assign remappable_pin_oe_o[1] = pick(pin_live[1], func_oe_i, code_ff[1], port_oe_i[1]);
    assign pin_function_codes_o[9:5] = code_ff[1];

    // pin 2, even half of register 1
    assign pin_live[2] = code_live(code_ff[2]);
    assign remappable_pin_o[2] = pick(pin_live[2], func_out_i, code_ff[2], port_out_i[2]);
    assign remappable_pin_oe_o[2] = pick(pin_live[2], func_oe_i, code_ff[2], port_oe_i[2]);
    assign pin_function_codes_o[14:10] = code_ff[2];

    // pin 3, odd half of register 1
    assign pin_live[3] = code_live(code_ff[3]);
    assign remappable_pin_o[3] = pick(pin_live[3], func_out_i, code_ff[3], port_out_i[3]);
    assign remappable_pin_oe_o[3] = pick(pin_live[3], func_oe_i, code_ff[3], port_oe_i[3]);
    assign pin_function_codes_o[19:15] = code_ff[3];

    // pin 4, even half of register 2
    assign pin_live[4] = code_live(code_ff[4]);
    assign remappable_pin_o[4] = pick(pin_live[4], func_out_i, code_ff[4], port_out_i[4]);
    assign remappable_pin_oe_o[4] = pick(pin_live[4], func_oe_i, code_ff[4], port_oe_i[4]);
    assign pin_function_codes_o[24:20] = code_ff[4];

    // pin 5, odd half of register 2
    assign pin_live[5] = code_live(code_ff[5]);
    assign remappable_pin_o[5] = pick(pin_live[5], func_out_i, code_ff[5], port_out_i[5]);
    assign remappable_pin_oe_o[5] = pick(pin_live[5], func_oe_i, code_ff[5], port_oe_i[5]);
    assign pin_function_codes_o[29:25] = code_ff[5];

    // pin 6, even half of register 3
    assign pin_live[6] = code_live(code_ff[6]);
    assign remappable_pin_o[6] = pick(pin_live[6], func_out_i, code_ff[6], port_out_i[6]);
    assign remappable_pin_oe_o[6] = pick(pin_live[6], func_oe_i, code_ff[6], port_oe_i[6]);
    assign pin_function_codes_o[34:30] = code_ff[6];

    // pin 7, odd half of register 3
    assign pin_live[7] = code_live(code_ff[7]);
    assign remappable_pin_o[7] = pick(pin_live[7], func_out_i, code_ff[7], port_out_i[7]);
    assign remappable_pin_oe_o[7] = pick(pin_live[7], func_oe_i, code_ff[7], port_oe_i[7]);
    assign pin_function_codes_o[39:35] = code_ff[7];

    // pin 8, even half of register 4
    assign pin_live[8] = code_live(code_ff[8]);
    assign remappable_pin_o[8] = pick(pin_live[8], func_out_i, code_ff[8], port_out_i[8]);
    assign remappable_pin_oe_o[8] = pick(pin_live[8], func_oe_i, code_ff[8], port_oe_i[8]);
    assign pin_function_codes_o[44:40] = code_ff[8];

    // pin 9, odd half of register 4
    assign pin_live[9] = code_live(code_ff[9]);
    assign remappable_pin_o[9] = pick(pin_live[9], func_out_i, code_ff[9], port_out_i[9]);
    assign remappable_pin_oe_o[9] = pick(pin_live[9], func_oe_i, code_ff[9], port_oe_i[9]);
    assign pin_function_codes_o[49:45] = code_ff[9];
endmodule
`default_nettype wire

// ==== tb/rosel_monitor.sv ====
// register port checks
`timescale 1ns/1ps
`default_nettype none
module rosel_monitor (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic wb_err_o,
    input wire logic [49:0] pin_function_codes_o
);
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    wire logic rq = wb_cyc_i & wb_stb_i & !wb_ack_o & !wb_err_o;
    a_even_write: assert property (rq & wb_we_i & wb_sel_i[0] & wb_adr_i == 8'h00 |=>
        pin_function_codes_o[4:0] == $past(wb_dat_i[4:0])) else $error("even code");
    a_odd_write: assert property (rq & wb_we_i & wb_sel_i[1] & wb_adr_i == 8'h04 |=>
        pin_function_codes_o[19:15] == $past(wb_dat_i[12:8])) else $error("odd code");
    a_read_back: assert property (rq & !wb_we_i & wb_adr_i == 8'h00 |=> wb_ack_o &&
        wb_dat_o[4:0] == pin_function_codes_o[4:0]) else $error("read code");
    a_unused_zero: assert property (wb_ack_o & !wb_we_i |-> !(wb_dat_o & 32'hFFFFE0E0))
        else $error("unused bits");
    a_unmapped_err: assert property (rq & wb_adr_i == 8'h14 |=> wb_err_o & !wb_ack_o)
        else $error("unmapped");
    a_reset_clear: assert property (@(posedge clk_i) disable iff (1'b0) rst_i |=>
        pin_function_codes_o == 50'h0) else $error("reset codes");
endmodule
`default_nettype wire

// ==== tb/remappable_output_select_test.sv ====
// bench for the output select block
`timescale 1ns/1ps
`default_nettype none
module remappable_output_select_test;
    logic clk = 0, rst = 1, cyc = 0, we = 0, ack, err;
    logic [7:0] adr = 0;
    logic [3:0] sel = 4'hF;
    logic [31:0] dw = 0, dr, fo = 0, foe = 0, s = 32'hD583A309, v[5], q[$];
    logic [9:0] po = 0, ppe = 0, pin, poe;
    logic last_err = 0;
    logic [49:0] cd;
    int failures = 0, checked = 0;
    always #5 clk = !clk;
    rosel_top DUT (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
        .wb_adr_i(adr), .wb_dat_i(dw), .wb_sel_i(sel), .wb_dat_o(dr), .wb_ack_o(ack),
        .wb_err_o(err), .func_out_i(fo), .func_oe_i(foe), .port_out_i(po), .port_oe_i(ppe),
        .remappable_pin_o(pin), .remappable_pin_oe_o(poe), .pin_function_codes_o(cd));
    task chk(input logic [49:0] x, input logic [49:0] e);
        checked++;
        if (x !== e) begin
            failures++;
            $display("[FAIL] %0t seen %h exp %h", $time, x, e);
        end
    endtask
    task bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge clk);
        {cyc, adr, we, dw} <= {1'b1, a, w, d};
        do @(posedge clk); while (!(ack | err));
        last_err = err;
        cyc <= 0;
    endtask
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task pins_check;
        for (int p = 0; p < 10; p++) begin
            automatic logic [4:0] c = v[p / 2][p % 2 * 8 +: 5];
            chk(pin[p], c ? fo[c] : po[p]);
            chk(poe[p], c ? foe[c] : ppe[p]);
            chk(cd[p * 5 +: 5], c);
        end
    endtask
    task finish_test;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    always @(negedge clk) if (ack & !we) chk(dr, q.pop_front());
    initial begin
        repeat (3) @(posedge clk);
        rst <= 0;
        @(negedge clk) chk(cd, 0);
        for (int k = 0; k < 5; k++) begin
            s = lfsr(s);
            v[k] = s;
            bus(8'(k * 4), 1, s);
            q.push_back(s & 32'h1F1F);
            bus(8'(k * 4), 0, 0);
        end
        s = lfsr(s);
        {fo, foe, po, ppe} <= {s, ~s, s[19:10], s[29:20]};
        @(negedge clk);
        pins_check;
        v[0] = 0;
        bus(8'h00, 1, 0);
        @(negedge clk);
        pins_check;
        bus(8'h14, 1, s);
        chk(last_err, 1);
        @(negedge clk);
        pins_check;
        rst <= 1;
        @(posedge clk) rst <= 0;
        @(negedge clk) chk(cd, 0);
        v = '{default: 0};
        pins_check;
        q.push_back(0);
        bus(8'h10, 0, 0);
        finish_test;
    end
    initial begin
        #20000;
        failures++;
        finish_test;
    end
endmodule
bind rosel_top rosel_monitor mon (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
    .pin_function_codes_o(pin_function_codes_o));
`default_nettype wire
